// ---- fctl_regs.svh ----
// offsets, field positions, reset values and timing counts of the flash protection controller
// How it works
// - Host writes ones into every reserved lock bit so they stay unchanged.
// - Unlock loads four password words in any order; match needs all four.
// - Unlock commands accepted at most once per 100 us plus or minus 20.
// - Host programs and verifies password before programming the password mode bit.
`ifndef FCTL_REGS_SVH
`define FCTL_REGS_SVH
`define FC_CLK_MHZ       50
`define FC_ADDR_W        26
`define FC_DATA_W        16
`define FC_REG_CTRL      8'h00
`define FC_REG_DATA      8'h04
`define FC_REG_STAT      8'h08
`define FC_REG_LOCK      8'h0C
`define FC_REG_PW_BASE   4'h1
`define FC_LOCK_CUST     6
`define FC_LOCK_PWMODE   2
`define FC_LOCK_PERS     1
`define FC_LOCK_FACT     0
`define FC_LOCK_USED     16'h0047
`define FC_LOCK_RESET    16'hFFFF
`define FC_SR_FAIL       4
`define FC_SR_ABORT      3
`define FC_TOGGLE        6
`define FC_ADR_UNLK1     26'h0000555
`define FC_ADR_UNLK2     26'h00002AA
`define FC_DAT_UNLK1     16'h00AA
`define FC_DAT_UNLK2     16'h0055
`define FC_DAT_LOCK_ASO  16'h0040
`define FC_DAT_PW_ASO    16'h0060
`define FC_DAT_GUARD_ASO 16'h0050
`define FC_DAT_PROG      16'h00A0
`define FC_DAT_PW_UNLK   16'h0025
`define FC_DAT_PW_CNT    16'h0003
`define FC_DAT_PW_GO     16'h0029
`define FC_DAT_SR_READ   16'h0070
`define FC_DAT_EXIT1     16'h0090
`define FC_DAT_EXIT2     16'h0000
`define FC_PULSE_NS      50
`define FC_GAP_NS        30
`define FC_PULSE_CYC     ((`FC_PULSE_NS * `FC_CLK_MHZ + 999) / 1000)
`define FC_GAP_CYC       ((`FC_GAP_NS * `FC_CLK_MHZ + 999) / 1000)
`define FC_UNLOCK_GAP_US 100
`define FC_UNLOCK_TOL_US 20
`define FC_UNLOCK_CYC    ((`FC_UNLOCK_GAP_US + `FC_UNLOCK_TOL_US) * `FC_CLK_MHZ)
`define FC_POLL_LIMIT    16'hFFFF
`endif

// ---- fctl_pkg.sv ----
// types shared by the flash protection controller
package fctl_pkg;
  `include "fctl_regs.svh"
  typedef enum logic [2:0] {
    OP_NONE, OP_LOCK_PROG, OP_LOCK_READ, OP_PW_PROG, OP_PW_VERIFY, OP_PW_UNLOCK, OP_GUARD_CLEAR
  } fctl_op_t;
  typedef enum logic [1:0] {K_WR, K_RD, K_POLL} fctl_kind_t;
  typedef struct packed {
    fctl_kind_t             kind;
    logic [`FC_ADDR_W-1:0]  addr;
    logic [`FC_DATA_W-1:0]  data;
    logic                   pw;
    logic                   last;
  } fctl_step_t;
  typedef struct packed {
    logic                   ce_n;
    logic                   we_n;
    logic                   oe_n;
    logic [`FC_ADDR_W-1:0]  addr;
    logic [`FC_DATA_W-1:0]  dq_o;
    logic                   dq_oe;
  } fctl_pins_t;
endpackage

// ---- fctl_pwmem.sv ----
// four-word password store with registered read data
`timescale 1ns/1ps
module fctl_pwmem #(
  parameter int W = 16,
  parameter int D = 4,
  parameter int AW = 2
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] wa,
  input  wire logic [W-1:0]  wd,
  input  wire logic [AW-1:0] ra,
  output logic [W-1:0]       rd
);
  logic [W-1:0] mem [D];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[wa] <= wd;
    end
    rd <= mem[ra];
  end
endmodule

// ---- fctl_cycle.sv ----
// one asynchronous flash bus cycle, write or read, on the parallel pins
`timescale 1ns/1ps
`include "fctl_regs.svh"
module fctl_cycle
  import fctl_pkg::*;
#(
  parameter int PULSE = `FC_PULSE_CYC,
  parameter int GAP   = `FC_GAP_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  start,
  input  wire logic                  wr,
  input  wire logic [`FC_ADDR_W-1:0] addr,
  input  wire logic [`FC_DATA_W-1:0] wdata,
  input  wire logic [`FC_DATA_W-1:0] dq_in,
  output logic                       done,
  output logic [`FC_DATA_W-1:0]      rdata,
  output fctl_pkg::fctl_pins_t       pins
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_GAP} fctl_cst_t;
  fctl_cst_t  st;
  logic [7:0] cnt;
  wire        cnt_end = (cnt == 8'h00);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st    <= C_IDLE;
      cnt   <= 8'h00;
      done  <= 1'b0;
      rdata <= 16'h0000;
      pins  <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
    end else begin
      done <= 1'b0;
      case (st)
        C_IDLE: if (start) begin
          pins.addr  <= addr;
          pins.dq_o  <= wdata;
          pins.dq_oe <= wr;
          pins.ce_n  <= 1'b0;
          st         <= C_SETUP;
        end
        C_SETUP: begin
          pins.we_n <= ~pins.dq_oe;
          pins.oe_n <= pins.dq_oe;
          cnt       <= 8'(PULSE - 1);
          st        <= C_PULSE;
        end
        C_PULSE: if (cnt_end) begin
          // sample at the end of the strobe so access time has passed
          if (!pins.dq_oe) begin
            rdata <= dq_in;
          end
          pins.we_n <= 1'b1;
          pins.oe_n <= 1'b1;
          cnt       <= 8'(GAP - 1);
          st        <= C_GAP;
        end else begin
          cnt <= cnt - 8'h01;
        end
        C_GAP: if (cnt_end) begin
          pins.ce_n  <= 1'b1;
          pins.dq_oe <= 1'b0;
          done       <= 1'b1;
          st         <= C_IDLE;
        end else begin
          cnt <= cnt - 8'h01;
        end
        default: st <= C_IDLE;
      endcase
    end
  end
endmodule

// ---- fctl_top.sv ----
// host controller for the flash lock register, password and sector-bit guard
`timescale 1ns/1ps
`include "fctl_regs.svh"
module fctl_top
  import fctl_pkg::*;
#(
  parameter int UNLOCK_CYC = `FC_UNLOCK_CYC,
  parameter int POLL_LIMIT = `FC_POLL_LIMIT
) (
  input  wire logic                  CLK,
  input  wire logic                  NRST,
  input  wire logic [7:0]            ADDR,
  input  wire logic [31:0]           WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic [31:0]                RDATA,
  output fctl_pkg::fctl_pins_t       PINS,
  input  wire logic [`FC_DATA_W-1:0] DQ_IN,
  input  wire logic                  READY_BUSY
);
  import fctl_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_PREP, S_ISSUE, S_WAIT, S_NEXT} fctl_st_t;

  logic [1:0] rst_q;
  wire        rst_n = rst_q[1];
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  // step table: every sequence opens with the two unlock writes
  function automatic fctl_step_t step_of(input fctl_op_t op, input logic [3:0] s,
                                         input logic [1:0] idx, input logic [15:0] lockv);
    fctl_step_t r;
    r = '{kind: K_WR, addr: '0, data: '0, pw: 1'b0, last: 1'b0};
    if (s == 4'd0) begin
      r.addr = `FC_ADR_UNLK1;
      r.data = `FC_DAT_UNLK1;
    end else if (s == 4'd1) begin
      r.addr = `FC_ADR_UNLK2;
      r.data = `FC_DAT_UNLK2;
    end else begin
      case (op)
        OP_LOCK_PROG, OP_LOCK_READ: case (s)
          4'd2: begin r.addr = `FC_ADR_UNLK1; r.data = `FC_DAT_LOCK_ASO; end
          4'd3: r.data = (op == OP_LOCK_PROG) ? `FC_DAT_PROG : `FC_DAT_EXIT2;
          4'd4: begin
            r.kind = (op == OP_LOCK_PROG) ? K_WR : K_RD;
            r.data = lockv | ~`FC_LOCK_USED;
          end
          4'd5: r.kind = (op == OP_LOCK_PROG) ? K_POLL : K_WR;
          4'd6: r.data = `FC_DAT_EXIT1;
          default: r.last = 1'b1;
        endcase
        OP_PW_PROG, OP_PW_VERIFY: case (s)
          4'd2: begin r.addr = `FC_ADR_UNLK1; r.data = `FC_DAT_PW_ASO; end
          4'd3: r.data = (op == OP_PW_PROG) ? `FC_DAT_PROG : `FC_DAT_EXIT2;
          4'd4: begin
            r.kind = (op == OP_PW_PROG) ? K_WR : K_RD;
            r.addr = 26'(idx);
            r.pw   = 1'b1;
          end
          4'd5: r.kind = (op == OP_PW_PROG) ? K_POLL : K_WR;
          4'd6: r.data = `FC_DAT_EXIT1;
          default: r.last = 1'b1;
        endcase
        OP_PW_UNLOCK: case (s)
          4'd2: begin r.addr = `FC_ADR_UNLK1; r.data = `FC_DAT_PW_ASO; end
          4'd3: r.data = `FC_DAT_PW_UNLK;
          4'd4: r.data = `FC_DAT_PW_CNT;
          4'd5, 4'd6, 4'd7, 4'd8: begin
            r.addr = 26'(s - 4'd5);
            r.pw   = 1'b1;
          end
          4'd9: r.data = `FC_DAT_PW_GO;
          4'd10: r.kind = K_POLL;
          4'd11: r.data = `FC_DAT_EXIT1;
          default: r.last = 1'b1;
        endcase
        OP_GUARD_CLEAR: case (s)
          4'd2: begin r.addr = `FC_ADR_UNLK1; r.data = `FC_DAT_GUARD_ASO; end
          4'd3: r.data = `FC_DAT_PROG;
          4'd4: r.data = `FC_DAT_EXIT2;
          4'd5: r.kind = K_POLL;
          4'd6: r.data = `FC_DAT_EXIT1;
          default: r.last = 1'b1;
        endcase
        default: r.last = 1'b1;
      endcase
    end
    return r;
  endfunction

  fctl_st_t   st;
  fctl_op_t   op;
  logic [3:0] step;
  logic [1:0] idx;
  logic [1:0] ph;
  logic [15:0] lock_val;
  logic [15:0] lock_rd;
  logic [15:0] t1;
  logic [15:0] pcnt;
  logic [7:0]  fstat;
  logic [3:0]  pw_ok;
  logic        busy;
  logic        refused;
  logic        failed;
  logic        aborted;
  logic        timeout;
  logic [12:0] gap_cnt;
  logic        cyc_start;
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic [15:0] pw_rd;

  // register decode
  wire         pw_sel   = (ADDR[7:4] == `FC_REG_PW_BASE);
  wire         wr_ctrl  = WR && (ADDR == `FC_REG_CTRL);
  wire         wr_data  = WR && (ADDR == `FC_REG_DATA);
  wire         wr_pw    = WR && pw_sel;
  wire fctl_op_t req_op = fctl_op_t'(WDATA[2:0]);
  wire         pw_mode  = ~lock_rd[`FC_LOCK_PWMODE];
  wire         pers_mode = ~lock_rd[`FC_LOCK_PERS];
  wire         new_pw   = ~lock_val[`FC_LOCK_PWMODE];
  wire         new_pers = ~lock_val[`FC_LOCK_PERS];
  wire         gap_busy = (gap_cnt != 13'd0);

  // refusals keep the device out of the cases it would abort or ignore
  wire         bad_both  = new_pw && new_pers;
  wire         bad_mode  = (new_pw && pers_mode) || (new_pers && pw_mode);
  wire         bad_unver = new_pw && !pw_mode && (pw_ok != 4'hF);
  wire         bad_lock  = bad_both || bad_mode || bad_unver;
  wire         refuse    = (req_op == OP_LOCK_PROG && bad_lock)
                        || ((req_op == OP_PW_PROG || req_op == OP_PW_VERIFY) && pw_mode)
                        || (req_op == OP_PW_UNLOCK && gap_busy)
                        || (req_op == OP_NONE) || (req_op > OP_GUARD_CLEAR);
  wire         go        = wr_ctrl && (st == S_IDLE);

  wire fctl_step_t cur   = step_of(op, step, idx, lock_val);
  wire [1:0]   pw_ra     = (op == OP_PW_UNLOCK) ? 2'(step - 4'd5) : idx;
  wire         is_poll   = (cur.kind == K_POLL);
  wire         poll_wr   = is_poll && (ph == 2'd2);
  wire         cyc_wr    = is_poll ? poll_wr : (cur.kind == K_WR);
  wire [`FC_ADDR_W-1:0] cyc_addr = poll_wr ? `FC_ADR_UNLK1 : cur.addr;
  wire [15:0]  cyc_wdata = poll_wr ? `FC_DAT_SR_READ : (cur.pw ? pw_rd : cur.data);
  wire         toggling  = (t1[`FC_TOGGLE] != cyc_rdata[`FC_TOGGLE]);
  wire         poll_out  = (pcnt == 16'(POLL_LIMIT));
  wire [31:0]  stat_word = {15'h0000, READY_BUSY, fstat, 1'b0, pers_mode, pw_mode,
                            timeout, aborted, failed, refused, busy};

  assign cyc_start = (st == S_ISSUE);

  fctl_pwmem #(.W(16), .D(4), .AW(2)) u_pwmem (
    .clk (CLK),
    .we  (wr_pw),
    .wa  (ADDR[3:2]),
    .wd  (WDATA[15:0]),
    .ra  (pw_ra),
    .rd  (pw_rd)
  );

  fctl_cycle u_cycle (
    .clk   (CLK),
    .rst_n (rst_n),
    .start (cyc_start),
    .wr    (cyc_wr),
    .addr  (cyc_addr),
    .wdata (cyc_wdata),
    .dq_in (DQ_IN),
    .done  (cyc_done),
    .rdata (cyc_rdata),
    .pins  (PINS)
  );

  // register read, answered the cycle after the strobe
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h00000000;
    end else if (RD) begin
      RDATA <= (ADDR == `FC_REG_STAT) ? stat_word
             : (ADDR == `FC_REG_LOCK) ? {16'h0000, lock_rd}
             : (ADDR == `FC_REG_DATA) ? {16'h0000, lock_val}
             : (ADDR == `FC_REG_CTRL) ? {26'h0, idx, 1'b0, op}
             : 32'h00000000;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      lock_val <= `FC_LOCK_RESET;
      pw_ok    <= 4'h0;
    end else begin
      if (wr_data) begin
        lock_val <= WDATA[15:0];
      end
      if (st == S_WAIT && cyc_done && cur.kind == K_RD && op == OP_PW_VERIFY) begin
        pw_ok[idx] <= (cyc_rdata == pw_rd);
      end
      // a rewritten word needs a fresh verify, even if one ends now
      if (wr_pw) begin
        pw_ok[ADDR[3:2]] <= 1'b0;
      end
    end
  end

  // unlock spacing timer, started when an unlock sequence ends
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt <= 13'd0;
    end else if (st == S_NEXT && cur.last && op == OP_PW_UNLOCK) begin
      gap_cnt <= 13'(UNLOCK_CYC);
    end else if (gap_busy) begin
      gap_cnt <= gap_cnt - 13'd1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st      <= S_IDLE;
      op      <= OP_NONE;
      step    <= 4'd0;
      idx     <= 2'd0;
      ph      <= 2'd0;
      t1      <= 16'h0000;
      pcnt    <= 16'h0000;
      fstat   <= 8'h00;
      busy    <= 1'b0;
      refused <= 1'b0;
      failed  <= 1'b0;
      aborted <= 1'b0;
      timeout <= 1'b0;
      lock_rd <= `FC_LOCK_RESET;
    end else begin
      case (st)
        S_IDLE: if (go) begin
          refused <= refuse;
          if (!refuse) begin
            op      <= req_op;
            idx     <= WDATA[5:4];
            step    <= 4'd0;
            busy    <= 1'b1;
            failed  <= 1'b0;
            aborted <= 1'b0;
            timeout <= 1'b0;
            st      <= S_PREP;
          end
        end
        S_PREP: begin
          // one cycle for the password store read data to settle
          ph   <= 2'd0;
          pcnt <= 16'h0000;
          st   <= cur.last ? S_NEXT : S_ISSUE;
        end
        S_ISSUE: st <= S_WAIT;
        S_WAIT: if (cyc_done) begin
          st <= S_NEXT;
          if (cur.kind == K_RD && op == OP_LOCK_READ) begin
            lock_rd <= cyc_rdata;
          end
          if (is_poll) begin
            st <= S_ISSUE;
            ph <= ph + 2'd1;
            case (ph)
              2'd0: t1 <= cyc_rdata;
              2'd1: begin
                // a failed unlock keeps toggling, so the poll is bounded
                if (toggling && !poll_out) begin
                  ph   <= 2'd0;
                  pcnt <= pcnt + 16'h0001;
                end
                timeout <= toggling && poll_out;
              end
              2'd2: ;
              default: begin
                fstat   <= cyc_rdata[7:0];
                failed  <= cyc_rdata[`FC_SR_FAIL];
                aborted <= cyc_rdata[`FC_SR_ABORT];
                st      <= S_NEXT;
              end
            endcase
          end
        end
        S_NEXT: begin
          if (cur.last) begin
            busy <= 1'b0;
            st   <= S_IDLE;
          end else begin
            step <= step + 4'd1;
            st   <= S_PREP;
          end
        end
        default: st <= S_IDLE;
      endcase
    end
  end
endmodule

// ---- fctl_checker.sv ----
// checker on the controller's register port and flash pins
`timescale 1ns/1ps
`include "fctl_regs.svh"
module fctl_checker
  import fctl_pkg::*;
#(
  parameter int UNLOCK_CYC = 6000,
  parameter int POLL_LIMIT = 65535
) (
  input wire logic                  CLK,
  input wire logic                  NRST,
  input wire logic [7:0]            ADDR,
  input wire logic [31:0]           WDATA,
  input wire logic                  WR,
  input wire logic                  RD,
  input wire logic [31:0]           RDATA,
  input wire fctl_pkg::fctl_pins_t  PINS,
  input wire logic [`FC_DATA_W-1:0] DQ_IN,
  input wire logic                  READY_BUSY
);
  logic        we_q;
  logic [15:0] h [6];
  int          gap;
  // write history is taken on the first low cycle of we_n
  wire         wf  = we_q & ~PINS.we_n;
  wire         lkw = wf && h[1] == 16'h0040 && h[0] == 16'h00A0;
  wire         gow = wf && PINS.dq_o == 16'h0029;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      we_q <= 1'b1;
      gap  <= UNLOCK_CYC;
      h    <= '{default: 16'h0000};
    end else begin
      we_q <= PINS.we_n;
      if (wf) h <= '{PINS.dq_o, h[0], h[1], h[2], h[3], h[4]};
      if (wf && PINS.dq_o == 16'h0025) gap <= 0;
      else if (gap < UNLOCK_CYC) gap <= gap + 1;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  property p_res_ones;
    lkw |-> (PINS.dq_o | 16'h0047) == 16'hFFFF;
  endproperty
  a_res_ones: assert property (p_res_ones) else $error("reserved lock bits low");
  property p_one_mode;
    lkw |-> PINS.dq_o[2] || PINS.dq_o[1];
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("both mode bits sent");
  property p_four;
    gow |-> h[4] == 16'h0003 && h[5] == 16'h0025;
  endproperty
  a_four: assert property (p_four) else $error("unlock without four words");
  property p_gap;
    wf && PINS.dq_o == 16'h0025 |-> gap >= UNLOCK_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("unlock attempts too close");
  property p_pulse;
    wf |-> (!PINS.we_n) [*3] ##1 PINS.we_n;
  endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse length wrong");
  property p_sel;
    !PINS.we_n || !PINS.oe_n |-> !PINS.ce_n;
  endproperty
  a_sel: assert property (p_sel) else $error("strobe without chip select");
  property p_excl;
    PINS.we_n || PINS.oe_n;
  endproperty
  a_excl: assert property (p_excl) else $error("read and write strobes together");
  property p_drive;
    !PINS.we_n |-> PINS.dq_oe ##1 $stable(PINS.dq_o);
  endproperty
  a_drive: assert property (p_drive) else $error("write data not held");
  property p_rd_zero;
    RD && ADDR >= 8'h10 |=> RDATA == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("write-only or unmapped read not zero");
  c_lock: cover property (lkw);
  c_go: cover property (gow);
  c_unmap: cover property (RD && ADDR > 8'h1C);
endmodule
bind fctl_top fctl_checker #(.UNLOCK_CYC(UNLOCK_CYC), .POLL_LIMIT(POLL_LIMIT)) i_chk (
  .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .PINS(PINS), .DQ_IN(DQ_IN), .READY_BUSY(READY_BUSY)
);

// ---- fctl_flash_model.sv ----
// behavioural flash device: lock register, password store and sector-bit guard
`timescale 1ns/1ps
module fctl_flash_model
  import fctl_pkg::*;
#(
  parameter real GAP_NS = 80000.0
) (
  input  wire fctl_pkg::fctl_pins_t pins,
  output logic [15:0]              dq_in,
  output logic                     ready_busy
);
  logic [15:0] lock = 16'hFEFE;
  logic [15:0] pw [4] = '{default: 16'hFFFF};
  logic [15:0] uw [4];
  logic [15:0] rv;
  logic [15:0] last = 16'h0000;
  logic [15:0] d = 16'h0000;
  logic        guard = 1'b1;
  logic [7:0]  aso = 8'h00;
  logic        sr = 0, arm = 0, stuck = 0, fl = 0, fa = 0, ab = 0, tog = 0, hit;
  logic        psb = 1'b1;
  int          sq = 0, uc = 0, busy = 0, blen = 2;
  real         tl = -1.0e9;
  wire         rd_on = !pins.ce_n && !pins.oe_n;
  always_comb begin
    if (sr) rv = {8'h00, busy == 0, 2'b00, fl, fa, 3'b000};
    else if (busy != 0 || stuck) rv = {8'h00, ~d[7], tog, 6'h00};
    else if (aso == 8'h40) rv = lock;
    else if (aso == 8'h60) rv = lock[2] ? pw[pins.addr[1:0]] : 16'hFFFF;
    else rv = 16'hFFFF;
  end
  // no keeper on the bus: a released bus never repeats old data
  assign dq_in = rd_on ? rv : ~last;
  assign ready_busy = busy == 0 && !stuck;
  always @(posedge pins.oe_n) begin
    last = rv;
    if (sr) sr = 1'b0;
    else if (busy != 0 || stuck) begin
      tog = ~tog;
      if (busy != 0) busy--;
    end
  end
  always @(posedge pins.we_n) if (!pins.ce_n) begin
    d = pins.dq_o;
    if (pins.addr == 26'h555 && d == 16'h0070) sr = 1'b1;
    else if (uc >= 2 && uc < 6) begin
      uw[pins.addr[1:0]] = d;
      ab = ab | (pins.addr[25:2] != 0);
      uc++;
    end
    // a single exit write leaves the overlay, as the controller sends it
    else if (d == 16'h0090) begin
      aso = 8'h00;
      stuck = 1'b0;
    end
    else if (sq == 0 && d == 16'h00AA) begin
      sq = 1;
      fl = 1'b0;
      fa = 1'b0;
    end
    else if (sq == 1 && d == 16'h0055) sq = 2;
    else if (sq == 2) begin
      aso = d[7:0];
      sq = 0;
    end
    else if (arm) begin
      arm = 1'b0;
      busy = blen;
      if (aso == 8'h50) guard = 1'b0;
      else if (aso == 8'hC0) psb = psb & (d[0] | ~guard);
      else if (aso == 8'h60 && lock[2]) pw[pins.addr[1:0]] &= d;
      else if (aso == 8'h40 && (d[2] | d[1]) && (lock[2] | d[1]) && (lock[1] | d[2]))
        lock &= d | ~16'h0047;
      else if (aso == 8'h40) begin
        fl = 1'b1;
        fa = 1'b1;
      end
    end
    else if (d == 16'h00A0) arm = 1'b1;
    else if (d == 16'h0025) uc = 1;
    else if (d == 16'h0003 && uc == 1) uc = 2;
    else if (d == 16'h0029 && uc == 6) begin
      hit = !ab && uw[0] == pw[0] && uw[1] == pw[1] && uw[2] == pw[2] && uw[3] == pw[3]
            && !lock[2] && $realtime - tl >= GAP_NS;
      fl = !hit;
      fa = ab;
      stuck = !hit;
      guard = guard | hit;
      busy = blen;
      uc = 0;
      ab = 1'b0;
      tl = $realtime;
    end
  end
endmodule

// ---- fctl_top_tb.sv ----
// self-checking bench driving the controller's register port against the flash model
`timescale 1ns/1ps
module fctl_top_tb;
  import fctl_pkg::*;
  logic        CLK = 1'b0;
  logic        NRST = 1'b0;
  logic [7:0]  ADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic        WR = 1'b0;
  logic        RD = 1'b0;
  logic [31:0] RDATA;
  fctl_pins_t  PINS;
  logic [15:0] DQ_IN;
  logic        READY_BUSY;
  logic [31:0] s;
  int          num_errors = 0;
  int          checks_done = 0;
  logic [15:0] pwv [4] = '{16'hC3A5, 16'h5A3C, 16'h0F0F, 16'h7E81};
  fctl_top #(.UNLOCK_CYC(20), .POLL_LIMIT(8)) i_dut (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PINS(PINS), .DQ_IN(DQ_IN), .READY_BUSY(READY_BUSY));
  fctl_flash_model #(.GAP_NS(400.0)) i_flash (.pins(PINS), .dq_in(DQ_IN), .ready_busy(READY_BUSY));
  initial forever #10 CLK = ~CLK;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 s = RDATA;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(s & m, e);
  endtask
  // start an operation and wait, bounded, until busy drops
  task automatic run(input logic [2:0] o, input logic [1:0] i);
    int n = 0;
    wr(8'h00, {26'h0, i, 1'b0, o});
    repeat (3) @(posedge CLK);
    do begin
      rd(8'h08);
      n++;
    end while (s[0] !== 1'b0 && n < 3000);
    chk({31'h0, s[0]}, 32'h0);
  endtask
  task automatic tend(input string n);
    $display("test %s done, errors %0d", n, num_errors);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // the sequence needs roughly 2k cycles; 50k is a generous ceiling
  initial begin
    #1000000;
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    repeat (6) @(posedge CLK);
    NRST <= 1'b1;
    repeat (4) @(posedge CLK);
    wr(8'h20, 32'hFFFF_FFFF);
    rdc(8'h04, 32'hFFFF_FFFF, 32'h0000_FFFF);
    rdc(8'h0C, 32'hFFFF_FFFF, 32'h0000_FFFF);
    rdc(8'h20, 32'hFFFF_FFFF, 32'h0);
    rdc(8'h08, 32'h0001_001F, 32'h0001_0000);
    tend("reset");
    run(3'd2, 2'd0);
    rdc(8'h0C, 32'hFFFF_FFFF, 32'h0000_FEFE);
    rdc(8'h08, 32'h0000_0060, 32'h0);
    chk({31'h0, i_flash.guard}, 32'h1);
    wr(8'h04, 32'h0000_FFF9);
    run(3'd1, 2'd0);
    rdc(8'h08, 32'h0000_0002, 32'h0000_0002);
    chk({16'h0, i_flash.lock}, 32'h0000_FEFE);
    tend("mode bits together");
    // reserved bits 15:8 deliberately zero: the controller must force them high
    wr(8'h04, 32'h0000_00BF);
    run(3'd1, 2'd0);
    rdc(8'h08, 32'h0000_FF14, 32'h0000_8000);
    run(3'd2, 2'd0);
    rdc(8'h0C, 32'hFFFF_FFFF, 32'h0000_FEBE);
    tend("region lock");
    for (int i = 0; i < 4; i++) begin
      wr(8'h10 + 8'(4 * i), {16'h0, pwv[i]});
      run(3'd3, 2'(i));
    end
    rdc(8'h10, 32'hFFFF_FFFF, 32'h0);
    for (int i = 0; i < 4; i++) begin
      run(3'd4, 2'(i));
      chk({16'h0, i_flash.pw[i]}, {16'h0, pwv[i]});
    end
    wr(8'h04, 32'h0000_FFFB);
    run(3'd1, 2'd0);
    run(3'd2, 2'd0);
    rdc(8'h0C, 32'hFFFF_FFFF, 32'h0000_FEBA);
    rdc(8'h08, 32'h0000_0060, 32'h0000_0020);
    wr(8'h04, 32'h0000_FFFD);
    run(3'd1, 2'd0);
    rdc(8'h08, 32'h0000_0002, 32'h0000_0002);
    chk({16'h0, i_flash.lock}, 32'h0000_FEBA);
    run(3'd3, 2'd0);
    rdc(8'h08, 32'h0000_0002, 32'h0000_0002);
    tend("password mode");
    i_flash.blen = 6;
    run(3'd6, 2'd0);
    chk({31'h0, i_flash.guard}, 32'h0);
    rdc(8'h08, 32'h0000_FF10, 32'h0000_8000);
    wr(8'h10, {16'h0, pwv[0] ^ 16'h0001});
    run(3'd5, 2'd0);
    rdc(8'h08, 32'h0000_FF1C, 32'h0000_9014);
    chk({31'h0, i_flash.guard}, 32'h0);
    run(3'd5, 2'd0);
    rdc(8'h08, 32'h0000_0002, 32'h0000_0002);
    repeat (25) @(posedge CLK);
    wr(8'h10, {16'h0, pwv[0]});
    run(3'd5, 2'd0);
    rdc(8'h08, 32'h0000_FF1C, 32'h0000_8000);
    chk({31'h0, i_flash.guard}, 32'h1);
    tend("unlock");
    wr(8'h00, 32'h0000_0002);
    repeat (30) @(posedge CLK);
    NRST <= 1'b0;
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    repeat (4) @(posedge CLK);
    chk({29'h0, PINS.ce_n, PINS.we_n, PINS.oe_n}, 32'h0000_0007);
    rdc(8'h0C, 32'hFFFF_FFFF, 32'h0000_FFFF);
    rdc(8'h08, 32'h0000_0001, 32'h0);
    tend("second reset");
    test_done();
  end
endmodule
